/* hdl/conv_port_pkg.sv */
package conv_port_pkg;
  localparam int         WORD_BITS           = 20;
  localparam logic [2:0] READY_WINDOW_CYCLES = 3'h4;
  localparam logic [1:0] SCLK_HIGH_PHASE     = 2'h1;
  localparam logic [1:0] SCLK_RISE_PHASE     = 2'h0;
  // Pin order: select_n, shift clk, self mode, sleep_n, cal_b, bipolar
  localparam logic [5:0] PIN_SYNC_RESET      = 6'h26;
endpackage

/* hdl/converter_serial_output_port.sv */
`timescale 1ns/100ps
module converter_serial_output_port #(
  parameter int WORD_BITS = conv_port_pkg::WORD_BITS
) (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_reset,
  input  wire logic                 i_select_n,
  input  wire logic                 i_shift_clk,
  input  wire logic                 i_self_clocked_mode,
  input  wire logic                 i_sleep_n,
  input  wire logic                 i_cal_type_select_b,
  input  wire logic                 i_bipolar,
  input  wire logic [WORD_BITS-1:0] i_conv_word,
  input  wire logic                 i_conv_valid,
  output logic                      o_word_ready_flag,
  output logic                      o_serial_out_line,
  output logic                      o_serial_out_oe_n,
  output logic                      o_shift_clk_out,
  output logic                      o_shift_clk_oe_n,
  output logic                      o_offset_cal_from_input,
  output logic                      o_low_power
);
  localparam int             CW       = $clog2(WORD_BITS);
  localparam logic [CW-1:0]  LAST_BIT = CW'(WORD_BITS - 1);

  typedef enum logic {ST_IDLE, ST_SHIFT} port_state_t;

  port_state_t          state;
  port_state_t          next_state;
  logic [5:0]           pin_meta;
  logic [5:0]           pin_sync;
  logic                 sclk_prev;
  logic                 sel_prev;
  logic [2:0]           win_cnt;
  logic                 blocked;
  logic                 abort;
  logic [1:0]           phase;
  logic [CW-1:0]        bit_cnt;
  logic [WORD_BITS-1:0] out_word;
  logic [WORD_BITS-1:0] shreg;
  logic                 sdo_drive;
  logic                 sclk_drive;

  wire logic sel_n_s    = pin_sync[5];
  wire logic sclk_s     = pin_sync[4];
  wire logic self_mode  = pin_sync[3];
  wire logic asleep     = ~pin_sync[2];
  wire logic cal_b_s    = pin_sync[1];
  wire logic bipolar_s  = pin_sync[0];
  wire logic sel_fall   = sel_prev & ~sel_n_s;
  wire logic in_window  = win_cnt != 3'h0;
  wire logic shifting   = state == ST_SHIFT;
  wire logic ext_fall   = ~self_mode & sclk_prev & ~sclk_s;
  wire logic self_fall  = self_mode & (phase == conv_port_pkg::SCLK_HIGH_PHASE);
  wire logic bit_edge   = shifting & (self_mode ? self_fall : ext_fall);
  wire logic last_bit   = bit_cnt == LAST_BIT;
  wire logic word_end   = bit_edge & (last_bit | abort);
  wire logic start      = ~shifting & ~sel_n_s & ~in_window & ~blocked & ~asleep;
  wire logic [WORD_BITS-1:0] coded_word;

  assign coded_word = {i_conv_word[WORD_BITS-1] ^ bipolar_s, i_conv_word[WORD_BITS-2:0]};

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE:  if (start) next_state = ST_SHIFT;
      ST_SHIFT: if (word_end || asleep) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  assign o_serial_out_line = shreg[WORD_BITS-1];
  assign o_serial_out_oe_n = ~sdo_drive;
  assign o_shift_clk_oe_n  = ~sclk_drive;

  // Pins are asynchronous to the core clock, so two stages each
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      pin_meta <= conv_port_pkg::PIN_SYNC_RESET;
      pin_sync <= conv_port_pkg::PIN_SYNC_RESET;
    end else begin
      pin_meta <= {i_select_n, i_shift_clk, i_self_clocked_mode,
                   i_sleep_n, i_cal_type_select_b, i_bipolar};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sclk_prev <= 1'b0;
      sel_prev  <= 1'b1;
      o_offset_cal_from_input <= 1'b0;
      o_low_power <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
      sel_prev  <= sel_n_s;
      o_offset_cal_from_input <= ~cal_b_s;
      o_low_power <= asleep;
    end
  end

  // Window opens when a fresh word lands; a set beats the clear
  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      win_cnt           <= 3'h0;
      o_word_ready_flag <= 1'b0;
      out_word          <= '0;
    end else begin
      if (i_conv_valid) begin
        win_cnt           <= conv_port_pkg::READY_WINDOW_CYCLES;
        o_word_ready_flag <= 1'b1;
        out_word          <= coded_word;
      end else begin
        if (in_window) win_cnt <= win_cnt - 3'h1;
        if (word_end && !abort) o_word_ready_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      blocked <= 1'b0;
    end else if (sel_n_s) begin
      blocked <= 1'b0;
    end else if ((sel_fall && in_window) || word_end) begin
      blocked <= 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      state      <= ST_IDLE;
      shreg      <= '0;
      bit_cnt    <= '0;
      abort      <= 1'b0;
      phase      <= 2'h0;
      sdo_drive  <= 1'b0;
      sclk_drive <= 1'b0;
    end else begin
      state      <= next_state;
      sdo_drive  <= next_state == ST_SHIFT;
      sclk_drive <= (next_state == ST_SHIFT) && self_mode;
      if (start) begin
        shreg   <= out_word;
        bit_cnt <= '0;
        abort   <= 1'b0;
        phase   <= 2'h0;
      end else if (shifting) begin
        phase <= phase + 2'h1;
        if (sel_n_s) abort <= 1'b1;
        if (bit_edge && !word_end) begin
          shreg   <= {shreg[WORD_BITS-2:0], 1'b0};
          bit_cnt <= bit_cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_shift_clk_out <= 1'b0;
    end else begin
      o_shift_clk_out <= shifting && self_mode && !asleep
                         && (phase == conv_port_pkg::SCLK_RISE_PHASE);
    end
  end

  a_abort_release: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (bit_edge && abort) |=> o_serial_out_oe_n && o_shift_clk_oe_n)
    else $error("Lines not released after deselect");

  a_abort_hold: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (shifting && abort && !bit_edge && !asleep)
    |=> !o_serial_out_oe_n && $stable(o_serial_out_line))
    else $error("Bit cut short after deselect");

  a_window_ignore: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (!shifting && in_window) |=> o_serial_out_oe_n)
    else $error("Select honoured inside ready window");

  a_ext_fall_shift: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (shifting && ext_fall && !word_end && !asleep)
    |=> o_serial_out_line == $past(shreg[WORD_BITS-2]))
    else $error("Data not advanced on shift clock fall");

  a_cal_source: assert property (@(posedge i_core_clk) disable iff (i_reset)
    $fell(i_cal_type_select_b) |-> ##3 o_offset_cal_from_input)
    else $error("Offset cal source not taken from input");

  a_offset_binary: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (i_conv_valid && bipolar_s)
    |=> out_word[WORD_BITS-1] != $past(i_conv_word[WORD_BITS-1]))
    else $error("Bipolar word not offset binary");

  a_ext_no_drive: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (shifting && !self_mode) |-> o_shift_clk_oe_n)
    else $error("Shift clock driven in external mode");

  a_self_duty: assert property (@(posedge i_core_clk) disable iff (i_reset)
    o_shift_clk_out |=> !o_shift_clk_out [*3])
    else $error("Self clock duty not one in four");

  a_select_start: assert property (@(posedge i_core_clk) disable iff (i_reset)
    start |=> !o_serial_out_oe_n && o_serial_out_line == $past(out_word[WORD_BITS-1]))
    else $error("Select did not start the word");

  a_flag_clear: assert property (@(posedge i_core_clk) disable iff (i_reset)
    (word_end && !abort && !i_conv_valid) |=> !o_word_ready_flag)
    else $error("Ready flag kept after full word");

  a_sleep_idle: assert property (@(posedge i_core_clk) disable iff (i_reset)
    asleep |=> o_serial_out_oe_n && o_shift_clk_oe_n && o_low_power)
    else $error("Port active while asleep");
endmodule

/* testbench/serial_host_model.sv */
`timescale 1ns/100ps
module serial_host_model (
  input  wire logic i_core_clk,
  input  wire logic i_self_mode,
  input  wire logic i_data,
  input  wire logic i_data_oe_n,
  input  wire logic i_clk_out,
  output logic      o_select_n,
  output logic      o_shift_clk
);
  logic line;
  // Released line shows the inverse so stale bits never pass
  assign line = i_data_oe_n ? ~i_data : i_data;
  initial begin
    o_select_n = 1'b1;
    o_shift_clk = 1'b0;
  end
  task automatic sel(input logic v);
    @(posedge i_core_clk) #2 o_select_n = v;
  endtask
  task automatic read_bits(input int n, output logic [19:0] w, output int g);
    w = '0;
    g = 0;
    sel(1'b0);
    if (!i_self_mode) begin
      repeat (8) @(posedge i_core_clk);
      // Step off the core edge so the pin never races its sampler
      #2;
      for (int k = 0; k < n; k++) begin
        #200 o_shift_clk = 1'b1;
        #195 w = {w[18:0], line};
        #5 o_shift_clk = 1'b0;
      end
    end else begin
      for (int k = 0; k < n; k++) begin
        g = 0;
        do begin
          @(posedge i_core_clk) #1 g++;
        end while (!i_clk_out && g < 200);
        w = {w[18:0], line};
      end
    end
    repeat (8) @(posedge i_core_clk);
    sel(1'b1);
  endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  logic        clk = 0, rst = 1, sm = 0, slp = 1, calb = 1, bip = 0, vld = 0;
  logic [19:0] word = '0, w;
  logic        flag, dat, doe, sco, scoe, cal, lp, sel_n, sclk;
  int          num_errors = 0, tests_run = 0, g;
  converter_serial_output_port i_converter_serial_output_port (.i_core_clk(clk),
    .i_reset(rst), .i_select_n(sel_n), .i_shift_clk(sclk), .i_self_clocked_mode(sm),
    .i_sleep_n(slp), .i_cal_type_select_b(calb), .i_bipolar(bip), .i_conv_word(word),
    .i_conv_valid(vld), .o_word_ready_flag(flag), .o_serial_out_line(dat),
    .o_serial_out_oe_n(doe), .o_shift_clk_out(sco), .o_shift_clk_oe_n(scoe),
    .o_offset_cal_from_input(cal), .o_low_power(lp));
  serial_host_model i_serial_host_model (.i_core_clk(clk), .i_self_mode(sm), .i_data(dat),
    .i_data_oe_n(doe), .i_clk_out(sco), .o_select_n(sel_n), .o_shift_clk(sclk));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic chk(input string n, input logic [19:0] e, input logic [19:0] v);
    tests_run++;
    if (v !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic load(input logic [19:0] v);
    @(posedge clk) #2 vld = 1;
    word = v;
    @(posedge clk) #2 vld = 0;
  endtask
  task automatic t_ext();
    sm = 0;
    load(20'hA5C3E);
    repeat (6) @(posedge clk);
    chk("flag", 1, flag);
    i_serial_host_model.read_bits(20, w, g);
    chk("word", 20'hA5C3E, w);
    repeat (4) @(posedge clk);
    chk("flag", 0, flag);
    $display("external clock test done");
  endtask
  task automatic t_window();
    @(posedge clk) #2 sm = 1;
    bip = 1;
    // Let the synchroniser settle the pins before the word lands
    repeat (3) @(posedge clk);
    load(20'h3C0F1);
    i_serial_host_model.sel(0);
    repeat (10) @(posedge clk);
    chk("oe_n", 1, doe);
    i_serial_host_model.sel(1);
    repeat (4) @(posedge clk);
    i_serial_host_model.read_bits(20, w, g);
    chk("word", 20'hBC0F1, w);
    chk("gap", 4, 20'(g));
    $display("window test done");
  endtask
  task automatic t_abort();
    int k;
    load(20'h12345);
    repeat (6) @(posedge clk);
    i_serial_host_model.read_bits(5, w, g);
    chk("part", 20'h00012, w);
    for (k = 0; k < 12 && doe !== 1'b1; k++) @(posedge clk) #2;
    if (k == 12) begin
      num_errors++;
      conclude();
    end
    chk("clk_oe_n", 1, scoe);
    chk("flag", 1, flag);
    $display("early deselect test done");
  endtask
  task automatic t_pins();
    @(posedge clk) #2 calb = 0;
    slp = 0;
    repeat (4) @(posedge clk);
    chk("cal", 1, cal);
    chk("low_power", 1, lp);
    @(posedge clk) #2 calb = 1;
    slp = 1;
    repeat (4) @(posedge clk);
    chk("cal", 0, cal);
    chk("low_power", 0, lp);
    $display("pin test done");
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #2 rst = 0;
    repeat (3) @(posedge clk);
    t_ext();
    t_window();
    t_abort();
    t_pins();
    conclude();
  end
endmodule
